// [eepc_cmd_ctrl.sv]
// Command sequencer top with AXI4-Lite register slave
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
module eepc_cmd_ctrl #(
  parameter int EE_BYTES   = 2048,
  parameter int SECT_BYTES = 4
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Verify read faults from the array
  input  wire logic        verify_read_fault,
  input  wire logic        verify_ecc_fault
);

  localparam int EE_WORDS   = EE_BYTES / 2;
  localparam int SECT_WORDS = SECT_BYTES / 2;
  localparam int AW         = $clog2(EE_WORDS);
  localparam int SW         = $clog2(SECT_WORDS);
  localparam logic [23:0] EE_LIMIT = eepc_pkg::EE_BASE + 24'(EE_BYTES);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [15:0] param_q [4];
  logic [2:0]  index_q;
  logic        command_complete_flag_q;
  logic        access_error_flag_q;
  logic        pviol_q;
  logic        verr_q;
  logic        vunc_q;
  logic [7:0]  pf_prot_q;
  logic [7:0]  ee_prot_q;
  logic [7:0]  pf_save_q;
  logic [7:0]  ee_save_q;
  logic        ovr_q;
  logic [15:0] cfg_key_q;
  logic [1:0]  mode_q;
  eepc_pkg::eepc_state_t st_q;

  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // ****************************************
  // Write channel handshake
  // ****************************************
  wire logic aw_take   = s_axi_awvalid & awready_q;
  wire logic w_take    = s_axi_wvalid & wready_q;
  wire logic wr_fire   = aw_have_q & w_have_q & !bvalid_q;
  wire logic bvalid_d  = wr_fire | (bvalid_q & !s_axi_bready);
  wire logic aw_have_d = wr_fire ? 1'b0 : (aw_have_q | aw_take);
  wire logic w_have_d  = wr_fire ? 1'b0 : (w_have_q | w_take);

  wire logic wr_param0 = wr_fire && (awaddr_q == eepc_pkg::OFS_PARAM0);
  wire logic wr_param1 = wr_fire && (awaddr_q == eepc_pkg::OFS_PARAM1);
  wire logic wr_param2 = wr_fire && (awaddr_q == eepc_pkg::OFS_PARAM2);
  wire logic wr_param3 = wr_fire && (awaddr_q == eepc_pkg::OFS_PARAM3);
  wire logic wr_index  = wr_fire && (awaddr_q == eepc_pkg::OFS_INDEX);
  wire logic wr_status = wr_fire && (awaddr_q == eepc_pkg::OFS_STATUS);
  wire logic wr_pfprot = wr_fire && (awaddr_q == eepc_pkg::OFS_PF_PROT);
  wire logic wr_eeprot = wr_fire && (awaddr_q == eepc_pkg::OFS_EE_PROT);
  wire logic wr_key    = wr_fire && (awaddr_q == eepc_pkg::OFS_CFG_KEY);
  wire logic wr_mode   = wr_fire && (awaddr_q == eepc_pkg::OFS_MODE);
  wire logic wr_ro     = wr_fire && (awaddr_q == eepc_pkg::OFS_PROT_ST);
  wire logic wr_mapped = wr_param0 | wr_param1 | wr_param2 | wr_param3 | wr_index
                       | wr_status | wr_pfprot | wr_eeprot | wr_key | wr_mode | wr_ro;

  wire logic [31:0] wmask = merge(32'h0, 32'hFFFFFFFF, wstrb_q);
  wire logic [31:0] wbits = wdata_q & wmask;

  // ****************************************
  // Launch decode
  // ****************************************
  wire logic        launch  = wr_status && command_complete_flag_q && wbits[eepc_pkg::ST_COMMAND_COMPLETE_FLAG_BIT];
  wire logic [7:0]  cmd     = param_q[0][15:8];
  wire logic        is_ers  = (cmd == eepc_pkg::CMD_ERASE_SECT);
  wire logic        is_ovr  = (cmd == eepc_pkg::CMD_PROT_OVR);
  wire logic [23:0] gaddr   = {param_q[0][7:0], param_q[1]};
  wire logic [23:0] ee_ofs  = gaddr - eepc_pkg::EE_BASE;
  wire logic [AW-1:0] word_ix = ee_ofs[AW:1];
  wire logic [AW-1:0] sect_base = (word_ix >> SW) << SW;
  wire logic [AW-1:0] sect_num  = word_ix >> SW;

  localparam int EEPROT_CNT_W_M1 = eepc_pkg::EEPROT_CNT_W - 1;
  // Sector erase checks
  wire logic ers_addr_bad = (gaddr < eepc_pkg::EE_BASE) || (gaddr >= EE_LIMIT);
  wire logic ers_acc = (index_q != eepc_pkg::IDX_001)
                     || !mode_q[eepc_pkg::MODE_ERASE_BIT]
                     || ers_addr_bad || gaddr[0];
  wire logic ers_prot = ee_prot_q[eepc_pkg::EEPROT_EN_BIT]
                     && (sect_num < AW'(ee_prot_q[EEPROT_CNT_W_M1:0]));

  // Override checks
  wire logic [1:0]  sel       = param_q[0][1:0];
  wire logic [15:0] key       = param_q[1];
  wire logic        key_valid = (key != eepc_pkg::KEY_ERASED);
  wire logic        feat_en   = (cfg_key_q != eepc_pkg::KEY_ERASED);
  wire logic        key_match = key_valid && feat_en && (key == cfg_key_q);
  wire logic        idx_ok    = (index_q == eepc_pkg::IDX_001)
                             || (index_q == eepc_pkg::IDX_010)
                             || (index_q == eepc_pkg::IDX_011);
  wire logic        sel_none  = (sel == eepc_pkg::SEL_NONE);
  wire logic        ovr_acc   = !idx_ok
                             || !mode_q[eepc_pkg::MODE_OVR_BIT]
                             || (!key_match && !ovr_q)
                             || (sel_none && (index_q != eepc_pkg::IDX_001))
                             || (sel_none && key_valid);

  wire logic ovr_apply   = launch && is_ovr && !ovr_acc && key_match;
  wire logic ovr_restore = launch && is_ovr && !ovr_acc && !key_match;
  wire logic ers_start   = launch && is_ers && !ers_acc && !ers_prot;
  wire logic acc_set     = launch && ((is_ers && ers_acc) || (is_ovr && ovr_acc)
                                      || (!is_ers && !is_ovr));
  wire logic pviol_set   = launch && is_ers && !ers_acc && ers_prot;

  // ****************************************
  // Eraser
  // ****************************************
  logic ers_done;
  logic ers_err;
  logic ers_unc;

  eepc_sector_eraser #(
    .WORDS      (EE_WORDS),
    .SECT_WORDS (SECT_WORDS)
  ) u_eraser (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .start      (ers_start),
    .sect_base  (sect_base),
    .rd_fault   (verify_read_fault),
    .unc_fault  (verify_ecc_fault),
    .done       (ers_done),
    .verify_err (ers_err),
    .verify_unc (ers_unc)
  );

  // ****************************************
  // Bus handshake registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= eepc_pkg::RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready_q <= !aw_have_d && !bvalid_d;
      wready_q  <= !w_have_d && !bvalid_d;
      bvalid_q  <= bvalid_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bresp_q <= wr_mapped ? eepc_pkg::RESP_OKAY : eepc_pkg::RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  wire logic ar_take  = s_axi_arvalid & arready_q;
  wire logic rvalid_d = ar_take | (rvalid_q & !s_axi_rready);

  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    if (s_axi_araddr == eepc_pkg::OFS_PARAM0) begin
      rd_word[15:0] = param_q[0];
    end else if (s_axi_araddr == eepc_pkg::OFS_PARAM1) begin
      rd_word[15:0] = param_q[1];
    end else if (s_axi_araddr == eepc_pkg::OFS_PARAM2) begin
      rd_word[15:0] = param_q[2];
    end else if (s_axi_araddr == eepc_pkg::OFS_PARAM3) begin
      rd_word[15:0] = param_q[3];
    end else if (s_axi_araddr == eepc_pkg::OFS_INDEX) begin
      rd_word[2:0] = index_q;
    end else if (s_axi_araddr == eepc_pkg::OFS_STATUS) begin
      rd_word[eepc_pkg::ST_COMMAND_COMPLETE_FLAG_BIT]   = command_complete_flag_q;
      rd_word[eepc_pkg::ST_ACCESS_ERROR_FLAG_BIT] = access_error_flag_q;
      rd_word[eepc_pkg::ST_PVIOL_BIT]  = pviol_q;
      rd_word[eepc_pkg::ST_VERR_BIT]   = verr_q;
      rd_word[eepc_pkg::ST_VUNC_BIT]   = vunc_q;
    end else if (s_axi_araddr == eepc_pkg::OFS_PF_PROT) begin
      rd_word[7:0] = pf_prot_q;
    end else if (s_axi_araddr == eepc_pkg::OFS_EE_PROT) begin
      rd_word[7:0] = ee_prot_q;
    end else if (s_axi_araddr == eepc_pkg::OFS_PROT_ST) begin
      rd_word[eepc_pkg::OVR_BIT] = ovr_q;
    end else if (s_axi_araddr == eepc_pkg::OFS_CFG_KEY) begin
      rd_word[15:0] = cfg_key_q;
    end else if (s_axi_araddr == eepc_pkg::OFS_MODE) begin
      rd_word[1:0] = mode_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= eepc_pkg::RESP_OKAY;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? eepc_pkg::RESP_OKAY : eepc_pkg::RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // Software registers and parameter array
  // ****************************************
  wire logic idle_wr = command_complete_flag_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        param_q[i] <= 16'h0000;
      end
      index_q   <= 3'h0;
      cfg_key_q <= eepc_pkg::RST_CFG_KEY;
      mode_q    <= eepc_pkg::RST_MODE;
    end else begin
      if (wr_param0 && idle_wr) begin
        param_q[0] <= wbits[15:0] | (param_q[0] & ~wmask[15:0]);
      end
      if (wr_param1 && idle_wr) begin
        param_q[1] <= wbits[15:0] | (param_q[1] & ~wmask[15:0]);
      end
      if (wr_param2 && idle_wr) begin
        param_q[2] <= wbits[15:0] | (param_q[2] & ~wmask[15:0]);
      end
      if (wr_param3 && idle_wr) begin
        param_q[3] <= wbits[15:0] | (param_q[3] & ~wmask[15:0]);
      end
      if (wr_index && idle_wr && wmask[0]) begin
        index_q <= wbits[2:0];
      end
      if (wr_key) begin
        cfg_key_q <= wbits[15:0] | (cfg_key_q & ~wmask[15:0]);
      end
      if (wr_mode && wmask[0]) begin
        mode_q <= wbits[1:0];
      end
    end
  end

  // ****************************************
  // Protection registers and save buffer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pf_prot_q <= eepc_pkg::RST_PF_PROT;
      ee_prot_q <= eepc_pkg::RST_EE_PROT;
      pf_save_q <= eepc_pkg::RST_PF_PROT;
      ee_save_q <= eepc_pkg::RST_EE_PROT;
      ovr_q     <= 1'b0;
    end else if (ovr_apply) begin
      pf_save_q <= pf_prot_q;
      ee_save_q <= ee_prot_q;
      if (sel[0]) begin
        pf_prot_q <= param_q[2][7:0];
      end
      if (sel[1]) begin
        ee_prot_q <= param_q[3][7:0];
      end
      ovr_q <= 1'b1;
    end else if (ovr_restore) begin
      pf_prot_q <= pf_save_q;
      ee_prot_q <= ee_save_q;
      ovr_q     <= 1'b0;
    end else begin
      if (wr_pfprot && wmask[0]) begin
        pf_prot_q <= wbits[7:0];
      end
      if (wr_eeprot && wmask[0]) begin
        ee_prot_q <= wbits[7:0];
      end
    end
  end

  // ****************************************
  // Command sequencer and status flags
  // ****************************************
  wire logic w1c_acc   = wr_status && wbits[eepc_pkg::ST_ACCESS_ERROR_FLAG_BIT];
  wire logic w1c_pviol = wr_status && wbits[eepc_pkg::ST_PVIOL_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q     <= eepc_pkg::ST_IDLE;
      command_complete_flag_q   <= 1'b1;
      access_error_flag_q <= 1'b0;
      pviol_q  <= 1'b0;
      verr_q   <= 1'b0;
      vunc_q   <= 1'b0;
    end else begin
      access_error_flag_q <= acc_set | (access_error_flag_q & !w1c_acc & !launch);
      pviol_q  <= pviol_set | (pviol_q & !w1c_pviol & !launch);
      case (st_q)
        eepc_pkg::ST_IDLE: begin
          if (launch) begin
            command_complete_flag_q <= 1'b0;
            verr_q <= 1'b0;
            vunc_q <= 1'b0;
            st_q   <= ers_start ? eepc_pkg::ST_ERASE : eepc_pkg::ST_FINISH;
          end
        end
        eepc_pkg::ST_ERASE: begin
          if (ers_done) begin
            verr_q <= ers_err;
            vunc_q <= ers_unc;
            st_q   <= eepc_pkg::ST_FINISH;
          end
        end
        default: begin
          command_complete_flag_q <= 1'b1;
          st_q   <= eepc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule

// [eepc_pkg.sv]
// Constants for the EEPROM erase and protection override command sequencer
package eepc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_PARAM0   = 8'h00;
  localparam logic [7:0] OFS_PARAM1   = 8'h04;
  localparam logic [7:0] OFS_PARAM2   = 8'h08;
  localparam logic [7:0] OFS_PARAM3   = 8'h0C;
  localparam logic [7:0] OFS_INDEX    = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_PF_PROT  = 8'h18;
  localparam logic [7:0] OFS_EE_PROT  = 8'h1C;
  localparam logic [7:0] OFS_PROT_ST  = 8'h20;
  localparam logic [7:0] OFS_CFG_KEY  = 8'h24;
  localparam logic [7:0] OFS_MODE     = 8'h28;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ST_COMMAND_COMPLETE_FLAG_BIT   = 7;
  localparam int ST_ACCESS_ERROR_FLAG_BIT = 5;
  localparam int ST_PVIOL_BIT  = 4;
  localparam int ST_VERR_BIT   = 1;
  localparam int ST_VUNC_BIT   = 0;
  localparam int OVR_BIT       = 0;
  localparam int MODE_ERASE_BIT = 0;
  localparam int MODE_OVR_BIT  = 1;
  localparam int EEPROT_EN_BIT = 7;
  localparam int EEPROT_CNT_W  = 6;

  // ****************************************
  // Command codes and values
  // ****************************************
  localparam logic [7:0]  CMD_ERASE_SECT = 8'h12;
  localparam logic [7:0]  CMD_PROT_OVR   = 8'h13;
  localparam logic [2:0]  IDX_001        = 3'h1;
  localparam logic [2:0]  IDX_010        = 3'h2;
  localparam logic [2:0]  IDX_011        = 3'h3;
  localparam logic [1:0]  SEL_NONE       = 2'h0;
  localparam logic [15:0] KEY_ERASED     = 16'hFFFF;
  localparam logic [15:0] WORD_ERASED    = 16'hFFFF;
  localparam logic [23:0] EE_BASE        = 24'h100000;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  RST_PF_PROT = 8'h00;
  localparam logic [7:0]  RST_EE_PROT = 8'h00;
  localparam logic [15:0] RST_CFG_KEY = 16'hFFFF;
  localparam logic [1:0]  RST_MODE    = 2'h3;

  // ****************************************
  // Bus responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_FINISH} eepc_state_t;

endpackage

// [eepc_props.sv]
// Bus and status checker for the command sequencer
`timescale 1ns/1ps
module eepc_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ****************************************
  // Properties
  // ****************************************
  logic [7:0] ra_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn) ra_q <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_r_wait; s_axi_rvalid && !s_axi_rready; endsequence
  property p_r_ans; s_ar_take |=> s_axi_rvalid; endproperty
  property p_r_hold; s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_ar_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_aw_blk; s_axi_bvalid |-> !(s_axi_awready || s_axi_wready); endproperty
  property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_idx; s_axi_rvalid && ra_q == eepc_pkg::OFS_INDEX |-> s_axi_rdata[31:3] == 29'h0;
  endproperty
  property p_pst; s_axi_rvalid && ra_q == eepc_pkg::OFS_PROT_ST |-> s_axi_rdata[31:1] == 31'h0;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  a_ar_blk: assert property (p_ar_blk) else $error("read taken while busy");
  a_aw_blk: assert property (p_aw_blk) else $error("write taken while busy");
  a_b_drop: assert property (p_b_drop) else $error("write response repeated");
  a_idx: assert property (p_idx) else $error("index wider than three bits");
  a_pst: assert property (p_pst) else $error("override status wide");
endmodule
bind eepc_cmd_ctrl eepc_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// [eepc_sector_eraser.sv]
// EEPROM array with sector erase and erase verify
`timescale 1ns/1ps
module eepc_sector_eraser #(
  parameter int WORDS      = 1024,
  parameter int SECT_WORDS = 2,
  parameter int AW         = $clog2(WORDS)
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Control
  input  wire logic          start,
  input  wire logic [AW-1:0] sect_base,
  // Read fault indications during verify
  input  wire logic          rd_fault,
  input  wire logic          unc_fault,
  // Result
  output logic               done,
  output logic               verify_err,
  output logic               verify_unc
);

  typedef enum logic [1:0] {ES_IDLE, ES_ERASE, ES_VERIFY} eepc_es_t;

  localparam logic [AW-1:0] LAST_OFS = AW'(SECT_WORDS - 1);

  logic [15:0]   mem [WORDS];
  eepc_es_t      st_q;
  logic [AW-1:0] ofs_q;
  logic [AW-1:0] base_q;
  logic          err_q;
  logic          unc_q;
  logic          done_q;

  wire logic [AW-1:0] waddr    = base_q + ofs_q;
  wire logic          last_ofs = (ofs_q == LAST_OFS);
  wire logic          blank    = (mem[waddr] == eepc_pkg::WORD_ERASED);

  // Erase one word a cycle, then read each back
  always_ff @(posedge aclk) begin
    if (st_q == ES_ERASE) begin
      mem[waddr] <= eepc_pkg::WORD_ERASED;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= ES_IDLE;
      ofs_q  <= '0;
      base_q <= '0;
      err_q  <= 1'b0;
      unc_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        ES_IDLE: begin
          if (start) begin
            st_q   <= ES_ERASE;
            base_q <= sect_base;
            ofs_q  <= '0;
            err_q  <= 1'b0;
            unc_q  <= 1'b0;
          end
        end
        ES_ERASE: begin
          ofs_q <= last_ofs ? '0 : ofs_q + 1'b1;
          if (last_ofs) begin
            st_q <= ES_VERIFY;
          end
        end
        default: begin
          err_q <= err_q | rd_fault | !blank;
          unc_q <= unc_q | unc_fault | !blank;
          ofs_q <= ofs_q + 1'b1;
          if (last_ofs) begin
            st_q   <= ES_IDLE;
            done_q <= 1'b1;
          end
        end
      endcase
    end
  end

  assign done       = done_q;
  assign verify_err = err_q;
  assign verify_unc = unc_q;

endmodule

// [tb.sv]
// Self-checking bench for the command sequencer
`timescale 1ns/1ps
module tb;
  // ****************************************
  // Bench
  // ****************************************
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, pa;
  logic [31:0] wdata = 32'h0, rdata, st;
  logic [3:0]  strb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        rdf = 1'b0, ecf = 1'b0, awready, wready, bvalid, arready, rvalid, f;
  logic [1:0]  bresp, rresp, rr;
  logic [15:0] key;
  logic [23:0] ad;
  int          n_errors = 0, samples_checked = 0, seed = 32'h3307, i;
  always #5 aclk = ~aclk;
  eepc_cmd_ctrl #(.EE_BYTES(2048), .SECT_BYTES(16)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .verify_read_fault(rdf),
    .verify_ecc_fault(ecf));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out;
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", {30'h0, bresp}, {30'h0, eepc_pkg::RESP_OKAY});
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    st = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic run(input logic [15:0] w0, w1, w2, w3, input logic [2:0] ix, input bit b);
    wr(eepc_pkg::OFS_PARAM0, {16'h0, w0});
    wr(eepc_pkg::OFS_PARAM1, {16'h0, w1});
    wr(eepc_pkg::OFS_PARAM2, {16'h0, w2});
    wr(eepc_pkg::OFS_PARAM3, {16'h0, w3});
    wr(eepc_pkg::OFS_INDEX, {29'h0, ix});
    wr(eepc_pkg::OFS_STATUS, 32'h80);
    st = 32'h0;
    if (b) begin
      rd(eepc_pkg::OFS_STATUS);
      chk("busy", {31'h0, st[7]}, 32'h0);
    end
    while (st[7] !== 1'b1) rd(eepc_pkg::OFS_STATUS);
  endtask
  task automatic ovr(input logic [1:0] s, input logic [15:0] k, w2, w3, input logic [2:0] ix);
    run({8'h13, 6'h0, s}, k, w2, w3, ix, 1'b0);
  endtask
  task automatic ers(input logic [23:0] a, input logic [2:0] ix, input bit b);
    run({eepc_pkg::CMD_ERASE_SECT, a[23:16]}, a[15:0], 16'h0, 16'h0, ix, b);
  endtask
  task automatic sc(input logic [7:0] e);
    chk("status", st, {24'h0, e});
  endtask
  task automatic prot(input logic [7:0] pf, ee, input logic ps);
    rd(eepc_pkg::OFS_PF_PROT);
    chk("pf_prot", st, {24'h0, pf});
    rd(eepc_pkg::OFS_EE_PROT);
    chk("ee_prot", st, {24'h0, ee});
    rd(eepc_pkg::OFS_PROT_ST);
    chk("override", st, {31'h0, ps});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h2C);
    chk("resp", {30'h0, rr}, {30'h0, eepc_pkg::RESP_SLVERR});
    prot(8'h00, 8'h00, 1'b0);
    ovr(2'h3, 16'h1234, 16'h5A, 16'h5A, 3'h3);
    sc(8'hA0);
    key = 16'($random(seed)) & 16'h7FFE;
    pa = 8'($random(seed));
    wr(eepc_pkg::OFS_CFG_KEY, {16'h0, key});
    ovr(2'h3, key, {8'h0, pa}, 16'h05, 3'h3);
    sc(8'h80);
    prot(pa, 8'h05, 1'b1);
    wr(eepc_pkg::OFS_PF_PROT, 32'h3C);
    ovr(2'h1, key, 16'hC3, 16'h33, 3'h2);
    strb <= 4'h0;
    wr(eepc_pkg::OFS_PF_PROT, 32'hFF);
    strb <= 4'hF;
    prot(8'hC3, 8'h05, 1'b1);
    wr(eepc_pkg::OFS_EE_PROT, 32'h44);
    ovr(2'h0, 16'hFFFF, 16'h0, 16'h0, 3'h1);
    prot(8'h3C, 8'h05, 1'b0);
    ovr(2'h0, key ^ 16'h1, 16'h0, 16'h0, 3'h1);
    sc(8'hA0);
    for (i = 0; i < 8; i++) begin
      ovr(i > 3 ? 2'h3 : 2'h0, key, 16'h77, 16'h77, 3'(i));
      sc(8'hA0);
    end
    prot(8'h3C, 8'h05, 1'b0);
    wr(eepc_pkg::OFS_MODE, 32'h0);
    ovr(2'h3, key, 16'h77, 16'h77, 3'h3);
    sc(8'hA0);
    ers(24'h100020, 3'h1, 1'b0);
    sc(8'hA0);
    wr(eepc_pkg::OFS_MODE, 32'h3);
    for (i = 0; i < 8; i++) begin
      ers(24'h100020, 3'(i), 1'b0);
      sc(i == 1 ? 8'h80 : 8'hA0);
    end
    ers(24'h100021, 3'h1, 1'b0);
    sc(8'hA0);
    ers(24'h100800, 3'h1, 1'b0);
    sc(8'hA0);
    run(16'h1400, 16'h0, 16'h0, 16'h0, 3'h1, 1'b0);
    sc(8'hA0);
    wr(eepc_pkg::OFS_EE_PROT, 32'h81);
    ers(24'h100004, 3'h1, 1'b0);
    sc(8'h90);
    wr(eepc_pkg::OFS_STATUS, 32'h30);
    rd(eepc_pkg::OFS_STATUS);
    sc(8'h80);
    ers(24'h10001E, 3'h1, 1'b1);
    sc(8'h80);
    ecf <= 1'b1;
    ers(24'h100040, 3'h1, 1'b0);
    chk("unc", {31'h0, st[0]}, 32'h1);
    ecf <= 1'b0;
    ovr(2'h3, key, 16'h11, 16'h81, 3'h3);
    sc(8'h80);
    for (i = 0; i < 6; i++) begin
      ad = 24'h100010 + (24'($random(seed)) & 24'h7DE);
      f = 1'($random(seed));
      rdf <= f;
      ers(ad, 3'h1, 1'b0);
      sc(f ? 8'h82 : 8'h80);
    end
    close_out;
  end
endmodule
